//--- hdl/pfg_pad_config.sv
// Purpose: Register bank setting pull resistors and open-drain behaviour of the keypad balls.
// Assumes: The serial command interpreter issues one-cycle byte read and write strobes on MCLK.
// Notes: Pad controls are decoded from next register values so they change with the register.
//
// Function
// - A pull selector of 00 means no pull, 01 pull-down, and any code with the upper bit set pull-up.
// - Row balls 0 to 4 own selectors at bits 1:0 up to 9:8 of the low-row pull register, each resetting to pull-down.
// - The high-row pull register at 0xAE holds row balls 8 to 10 at bits 1:0, 3:2, 5:4, each resetting to pull-down.
// - Row ball 11 sits at bits 7:6 of the high-row pull register and resets to no pull.
// - The column open-drain enable register at 0xE0 sets each column ball push-pull at 0, open-drain at 1, reset 0.
// - The column drive-source register at 0xE1 picks the open-drain stage and matters only while open-drain is on.
// - The row open-drain enable register at 0xE2 gives each row ball 0-7 push-pull at 0 or open-drain at 1, reset 0.
// - The row drive-source register at 0xE3 picks the open-drain stage for row balls 0-7 and resets to 0.
// - In open-drain mode a source bit of 0 only pulls low or floats, and 1 only drives high or floats.
// - The low-row pull register sits at 0xAC and covers row balls 0 to 7.
// - Row ball 11 keeps its pull setting whichever function owns the ball; it has no open-drain or drive-source control.
module pfg_pad_config
    import pfg_pkg::*;
(
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RESETN,
    // Register access from the command interpreter.
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // GPIO data for column and row balls 0-7.
    input wire logic [7:0] COL_DOUT,
    input wire logic [7:0] COL_DOE,
    input wire logic [7:0] ROW_DOUT,
    input wire logic [7:0] ROW_DOE,
    // Pull resistor controls for row balls 0-11.
    output logic [11:0] ROW_PULL_UP,
    output logic [11:0] ROW_PULL_DOWN,
    // Open-drain configuration.
    output logic [7:0] COL_OD_EN,
    output logic [7:0] COL_OD_SRC,
    output logic [7:0] ROW_OD_EN,
    output logic [7:0] ROW_OD_SRC,
    // Output transistor controls.
    output logic [7:0] COL_NMOS_ON,
    output logic [7:0] COL_PMOS_ON,
    output logic [7:0] ROW_NMOS_ON,
    output logic [7:0] ROW_PMOS_ON
);

    logic [15:0] row_low_pull_select_ff;
    logic [15:0] nxt_row_low_pull_select;
    logic [7:0] row_high_pull_select_ff;
    logic [7:0] nxt_row_high_pull_select;
    logic [7:0] column_open_drain_enable_ff;
    logic [7:0] nxt_column_open_drain_enable;
    logic [7:0] column_drive_source_select_ff;
    logic [7:0] nxt_column_drive_source_select;
    logic [7:0] row_low_open_drain_enable_ff;
    logic [7:0] nxt_row_low_open_drain_enable;
    logic [7:0] row_low_drive_source_select_ff;
    logic [7:0] nxt_row_low_drive_source_select;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    pfg_pull_s pull_ff;
    pfg_pull_s nxt_pull;
    pfg_drive_s col_drive_ff;
    pfg_drive_s nxt_col_drive;
    pfg_drive_s row_drive_ff;
    pfg_drive_s nxt_row_drive;

    // Register writes.
    always_comb
    begin
        nxt_row_low_pull_select = row_low_pull_select_ff;
        nxt_row_high_pull_select = row_high_pull_select_ff;
        nxt_column_open_drain_enable = column_open_drain_enable_ff;
        nxt_column_drive_source_select = column_drive_source_select_ff;
        nxt_row_low_open_drain_enable = row_low_open_drain_enable_ff;
        nxt_row_low_drive_source_select = row_low_drive_source_select_ff;
        if (REG_WR)
        begin
            case (REG_ADDR)
                PFG_ADDR_ROW_LOW_PULL_LO: nxt_row_low_pull_select[7:0] = REG_WDATA;
                PFG_ADDR_ROW_LOW_PULL_HI: nxt_row_low_pull_select[15:8] = REG_WDATA;
                PFG_ADDR_ROW_HIGH_PULL_LO: nxt_row_high_pull_select = REG_WDATA;
                PFG_ADDR_COL_OD_ENABLE: nxt_column_open_drain_enable = REG_WDATA;
                PFG_ADDR_COL_DRIVE_SOURCE: nxt_column_drive_source_select = REG_WDATA;
                PFG_ADDR_ROW_OD_ENABLE: nxt_row_low_open_drain_enable = REG_WDATA;
                PFG_ADDR_ROW_DRIVE_SOURCE: nxt_row_low_drive_source_select = REG_WDATA;
                // The reserved high byte at 0xAF is not writable, so it cannot drift.
                default: nxt_row_low_pull_select = row_low_pull_select_ff;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            row_low_pull_select_ff <= PFG_RST_ROW_LOW_PULL;
            row_high_pull_select_ff <= PFG_RST_ROW_HIGH_PULL;
            column_open_drain_enable_ff <= PFG_RST_OD_REG;
            column_drive_source_select_ff <= PFG_RST_OD_REG;
            row_low_open_drain_enable_ff <= PFG_RST_OD_REG;
            row_low_drive_source_select_ff <= PFG_RST_OD_REG;
        end
        else
        begin
            row_low_pull_select_ff <= nxt_row_low_pull_select;
            row_high_pull_select_ff <= nxt_row_high_pull_select;
            column_open_drain_enable_ff <= nxt_column_open_drain_enable;
            column_drive_source_select_ff <= nxt_column_drive_source_select;
            row_low_open_drain_enable_ff <= nxt_row_low_open_drain_enable;
            row_low_drive_source_select_ff <= nxt_row_low_drive_source_select;
        end
    end

    // Register reads; data is presented the cycle after the strobe.
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (REG_RD)
        begin
            case (REG_ADDR)
                PFG_ADDR_ROW_LOW_PULL_LO: nxt_rdata = row_low_pull_select_ff[7:0];
                PFG_ADDR_ROW_LOW_PULL_HI: nxt_rdata = row_low_pull_select_ff[15:8];
                PFG_ADDR_ROW_HIGH_PULL_LO: nxt_rdata = row_high_pull_select_ff;
                PFG_ADDR_ROW_HIGH_PULL_HI: nxt_rdata = PFG_RST_ROW_HIGH_RSVD;
                PFG_ADDR_COL_OD_ENABLE: nxt_rdata = column_open_drain_enable_ff;
                PFG_ADDR_COL_DRIVE_SOURCE: nxt_rdata = column_drive_source_select_ff;
                PFG_ADDR_ROW_OD_ENABLE: nxt_rdata = row_low_open_drain_enable_ff;
                PFG_ADDR_ROW_DRIVE_SOURCE: nxt_rdata = row_low_drive_source_select_ff;
                default: nxt_rdata = PFG_UNMAPPED_RDATA;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            rdata_ff <= PFG_UNMAPPED_RDATA;
        else
            rdata_ff <= nxt_rdata;
    end

    // Pad controls are decoded from the next register values and registered at the same edge
    // as the register itself, so the pad follows a write without an extra cycle of lag.
    pfg_pull_decode #(
        .BALLS(PFG_ROW_BALLS)
    ) u_pull_decode (
        .sel({nxt_row_high_pull_select, nxt_row_low_pull_select}),
        .pull(nxt_pull)
    );

    pfg_od_stage #(
        .WIDTH(PFG_OD_BALLS)
    ) u_col_stage (
        .od_en(nxt_column_open_drain_enable),
        .od_src(nxt_column_drive_source_select),
        .dout(COL_DOUT),
        .doe(COL_DOE),
        .drive(nxt_col_drive)
    );

    pfg_od_stage #(
        .WIDTH(PFG_OD_BALLS)
    ) u_row_stage (
        .od_en(nxt_row_low_open_drain_enable),
        .od_src(nxt_row_low_drive_source_select),
        .dout(ROW_DOUT),
        .doe(ROW_DOE),
        .drive(nxt_row_drive)
    );

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            pull_ff <= '0;
            col_drive_ff <= '0;
            row_drive_ff <= '0;
        end
        else
        begin
            pull_ff <= nxt_pull;
            col_drive_ff <= nxt_col_drive;
            row_drive_ff <= nxt_row_drive;
        end
    end

    // During reset the pull outputs read zero; the reset pulls appear at the first edge after release.
    assign REG_RDATA = rdata_ff;
    assign ROW_PULL_UP = pull_ff.up;
    assign ROW_PULL_DOWN = pull_ff.down;
    assign COL_OD_EN = column_open_drain_enable_ff;
    assign COL_OD_SRC = column_drive_source_select_ff;
    assign ROW_OD_EN = row_low_open_drain_enable_ff;
    assign ROW_OD_SRC = row_low_drive_source_select_ff;
    assign COL_NMOS_ON = col_drive_ff.nmos_on;
    assign COL_PMOS_ON = col_drive_ff.pmos_on;
    assign ROW_NMOS_ON = row_drive_ff.nmos_on;
    assign ROW_PMOS_ON = row_drive_ff.pmos_on;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    a_pull_up_code: assert property ($past(RESETN) |-> ROW_PULL_UP[11] == row_high_pull_select_ff[7])
        else $error("row 11 pull-up does not follow its selector");
    a_pull_down_code: assert property ($past(RESETN)
        |-> ROW_PULL_DOWN[4] == (row_low_pull_select_ff[9:8] == 2'h1))
        else $error("row 4 pull-down does not follow its selector");
    a_pull_exclusive: assert property ((ROW_PULL_UP & ROW_PULL_DOWN) == 12'h000)
        else $error("pull-up and pull-down on together");
    a_high_pull_write: assert property (REG_WR && REG_ADDR == 8'hae
        |=> ROW_PULL_DOWN[10] == ($past(REG_WDATA[5:4]) == 2'h1))
        else $error("high-row pull write did not reach ball 10");
    a_col_od_write: assert property (REG_WR && REG_ADDR == 8'he0 |=> COL_OD_EN == $past(REG_WDATA))
        else $error("column open-drain enable not updated next cycle");
    a_row_od_write: assert property (REG_WR && REG_ADDR == 8'he2 |=> ROW_OD_EN == $past(REG_WDATA))
        else $error("row open-drain enable not updated next cycle");
    a_row_src_write: assert property (REG_WR && REG_ADDR == 8'he3 |=> ROW_OD_SRC == $past(REG_WDATA))
        else $error("row drive source not updated next cycle");
    a_od_low_only: assert property (ROW_OD_EN[0] && !ROW_OD_SRC[0] |-> !ROW_PMOS_ON[0])
        else $error("open-drain low-side ball drove high");
    a_od_high_only: assert property (COL_OD_EN[0] && COL_OD_SRC[0] |-> !COL_NMOS_ON[0])
        else $error("open-drain high-side ball drove low");
    a_src_ignored: assert property ($past(RESETN) && !COL_OD_EN[1] && $past(COL_DOE[1] && COL_DOUT[1])
        |-> COL_PMOS_ON[1])
        else $error("push-pull ball blocked by drive source");
    a_rsvd_readback: assert property (REG_RD && REG_ADDR == 8'haf |=> REG_RDATA == 8'h5a)
        else $error("reserved pull byte did not read its reset value");
    a_unmapped_read: assert property (REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");

    // Write paths of the remaining bytes; each lands on the pads one cycle after the strobe.
    a_low_pull_write: assert property (REG_WR && REG_ADDR == PFG_ADDR_ROW_LOW_PULL_LO
        |=> ROW_PULL_DOWN[0] == ($past(REG_WDATA[1:0]) == PFG_PULL_DOWN))
        else $error("low-row pull write did not reach ball 0");
    a_low_hi_write: assert property (REG_WR && REG_ADDR == PFG_ADDR_ROW_LOW_PULL_HI
        |=> ROW_PULL_UP[7] == $past(REG_WDATA[7]))
        else $error("low-row upper pull byte did not reach ball 7");
    a_high_up_write: assert property (REG_WR && REG_ADDR == PFG_ADDR_ROW_HIGH_PULL_LO
        |=> ROW_PULL_UP[9:8] == {$past(REG_WDATA[3]), $past(REG_WDATA[1])})
        else $error("high-row pull write did not reach balls 8 and 9");
    a_high_dn_write: assert property (REG_WR && REG_ADDR == PFG_ADDR_ROW_HIGH_PULL_LO
        |=> ROW_PULL_DOWN[8] == ($past(REG_WDATA[1:0]) == PFG_PULL_DOWN))
        else $error("high-row pull write did not set ball 8 pull-down");
    a_col_src_write: assert property (REG_WR && REG_ADDR == PFG_ADDR_COL_DRIVE_SOURCE
        |=> COL_OD_SRC == $past(REG_WDATA))
        else $error("column drive source not updated next cycle");
    // The reserved byte has no flops behind it, so a write there must leave every selector alone.
    a_rsvd_no_write: assert property (REG_WR && REG_ADDR == PFG_ADDR_ROW_HIGH_PULL_HI
        |=> $stable(row_high_pull_select_ff) && $stable(row_low_pull_select_ff))
        else $error("write to reserved pull byte changed a selector");

    // Values right after reset release; a write taken at that first edge may change them legally.
    a_reset_pulls: assert property ($rose(RESETN) && !REG_WR
        |=> ROW_PULL_DOWN == 12'h7ff && ROW_PULL_UP == 12'h000)
        else $error("pull outputs wrong after reset");
    a_row11_reset: assert property ($rose(RESETN) && !REG_WR
        |=> !ROW_PULL_UP[11] && !ROW_PULL_DOWN[11])
        else $error("row 11 has a pull after reset");
    a_od_reset_zero: assert property ($rose(RESETN)
        |-> COL_OD_EN == PFG_RST_OD_REG && COL_OD_SRC == PFG_RST_OD_REG
            && ROW_OD_EN == PFG_RST_OD_REG && ROW_OD_SRC == PFG_RST_OD_REG)
        else $error("open-drain registers not cleared by reset");

    // Transistor controls follow the previous cycle's data under the current configuration.
    a_col_push_pull: assert property ($past(RESETN) && !COL_OD_EN[0] && $past(COL_DOE[0])
        |-> COL_NMOS_ON[0] != COL_PMOS_ON[0])
        else $error("push-pull column ball not driven by exactly one transistor");
    a_row_push_pull: assert property ($past(RESETN) && !ROW_OD_EN[2] && $past(ROW_DOE[2])
        |-> ROW_NMOS_ON[2] != ROW_PMOS_ON[2])
        else $error("push-pull row ball not driven by exactly one transistor");
    a_col_src_masked: assert property ($past(RESETN) && !COL_OD_EN[0] && $past(COL_DOE[0] && !COL_DOUT[0])
        |-> COL_NMOS_ON[0])
        else $error("push-pull column ball did not drive low");
    a_row_src_masked: assert property ($past(RESETN) && !ROW_OD_EN[1] && $past(ROW_DOE[1] && ROW_DOUT[1])
        |-> ROW_PMOS_ON[1])
        else $error("push-pull row ball did not drive high");
    a_od_low_float: assert property ($past(RESETN) && ROW_OD_EN[0] && !ROW_OD_SRC[0] && $past(ROW_DOUT[0])
        |-> !ROW_NMOS_ON[0] && !ROW_PMOS_ON[0])
        else $error("low-side open-drain ball not floating on a one");
    a_od_high_float: assert property ($past(RESETN) && COL_OD_EN[0] && COL_OD_SRC[0] && !$past(COL_DOUT[0])
        |-> !COL_NMOS_ON[0] && !COL_PMOS_ON[0])
        else $error("high-side open-drain ball not floating on a zero");

    // Decoding of the remaining selectors and the read data register.
    a_low_up_code: assert property ($past(RESETN)
        |-> ROW_PULL_UP[3:0] == {row_low_pull_select_ff[7], row_low_pull_select_ff[5],
            row_low_pull_select_ff[3], row_low_pull_select_ff[1]})
        else $error("rows 0 to 3 pull-up do not follow their selectors");
    a_pull_none: assert property ($past(RESETN) && row_high_pull_select_ff[1:0] == PFG_PULL_NONE
        |-> !ROW_PULL_UP[8] && !ROW_PULL_DOWN[8])
        else $error("row 8 has a pull while its selector is off");
    // Read data stands until the next read, so the host may fetch it late.
    a_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");

    c_od_low_pull: cover property (ROW_OD_EN[0] && !ROW_OD_SRC[0] && ROW_NMOS_ON[0]);
    c_od_high_drive: cover property (COL_OD_EN[0] && COL_OD_SRC[0] && COL_PMOS_ON[0]);
    c_row11_pull_up: cover property (ROW_PULL_UP[11]);
    c_src_masked: cover property (COL_OD_SRC[0] && !COL_OD_EN[0] && COL_NMOS_ON[0]);
    c_low_pull_read: cover property (REG_RD && REG_ADDR == 8'hac ##1 REG_RDATA == 8'h55);

endmodule // pfg_pad_config

//--- hdl/pfg_pkg.sv
// Purpose: Shared constants and types for the pad pull and open-drain configuration bank.
// Assumes: Byte-wide register access from the device's serial command interpreter.
// Notes: Sixteen-bit registers take two byte addresses, low byte at the even one.
package pfg_pkg;

    // Byte addresses of the register bank.
    localparam logic [7:0] PFG_ADDR_ROW_LOW_PULL_LO = 8'hac;
    localparam logic [7:0] PFG_ADDR_ROW_LOW_PULL_HI = 8'had;
    localparam logic [7:0] PFG_ADDR_ROW_HIGH_PULL_LO = 8'hae;
    localparam logic [7:0] PFG_ADDR_ROW_HIGH_PULL_HI = 8'haf;
    localparam logic [7:0] PFG_ADDR_COL_OD_ENABLE = 8'he0;
    localparam logic [7:0] PFG_ADDR_COL_DRIVE_SOURCE = 8'he1;
    localparam logic [7:0] PFG_ADDR_ROW_OD_ENABLE = 8'he2;
    localparam logic [7:0] PFG_ADDR_ROW_DRIVE_SOURCE = 8'he3;

    // Values after reset.
    localparam logic [15:0] PFG_RST_ROW_LOW_PULL = 16'h5555;
    localparam logic [7:0] PFG_RST_ROW_HIGH_PULL = 8'h15;
    localparam logic [7:0] PFG_RST_ROW_HIGH_RSVD = 8'h5a;
    localparam logic [7:0] PFG_RST_OD_REG = 8'h00;
    localparam logic [7:0] PFG_UNMAPPED_RDATA = 8'h00;

    // Pull selector codes; any code with the upper bit set means pull-up.
    localparam logic [1:0] PFG_PULL_NONE = 2'h0;
    localparam logic [1:0] PFG_PULL_DOWN = 2'h1;

    // Ball counts.
    localparam int PFG_ROW_BALLS = 12;
    localparam int PFG_OD_BALLS = 8;

    typedef struct packed {
        logic [PFG_ROW_BALLS-1:0] up;
        logic [PFG_ROW_BALLS-1:0] down;
    } pfg_pull_s;

    typedef struct packed {
        logic [PFG_OD_BALLS-1:0] nmos_on;
        logic [PFG_OD_BALLS-1:0] pmos_on;
    } pfg_drive_s;

endpackage

//--- hdl/pfg_pull_decode.sv
// Purpose: Decodes two-bit pull selectors into pull-up and pull-down enables.
// Assumes: Selectors are packed two bits per ball, ball 0 in the lowest bits.
// Notes: Purely combinational; the caller registers the result.
module pfg_pull_decode
    import pfg_pkg::*;
#(
    parameter int BALLS = PFG_ROW_BALLS
)
(
    // Selectors.
    input wire logic [2*BALLS-1:0] sel,
    // Pull enables.
    output pfg_pull_s pull
);

    // The pull struct has a fixed width, so no other ball count can be served.
    if (BALLS != PFG_ROW_BALLS)
    begin : g_bad_balls
        $error("pfg_pull_decode: BALLS must match the pull struct width");
    end

    always_comb
    begin
        for (int i = 0; i < BALLS; i++)
        begin
            pull.up[i] = sel[2*i+1];
            pull.down[i] = (sel[2*i +: 2] == PFG_PULL_DOWN);
        end
    end

endmodule // pfg_pull_decode

//--- hdl/pfg_od_stage.sv
// Purpose: Chooses which output transistors are on for a group of balls.
// Assumes: Data and output enable come from the GPIO logic on the same clock.
// Notes: The drive-source bit matters only while open-drain is enabled.
module pfg_od_stage
    import pfg_pkg::*;
#(
    parameter int WIDTH = PFG_OD_BALLS
)
(
    // Configuration.
    input wire logic [WIDTH-1:0] od_en,
    input wire logic [WIDTH-1:0] od_src,
    // Data from the GPIO logic.
    input wire logic [WIDTH-1:0] dout,
    input wire logic [WIDTH-1:0] doe,
    // Transistor controls.
    output pfg_drive_s drive
);

    // The drive struct has a fixed width, so no other ball count can be served.
    if (WIDTH != PFG_OD_BALLS)
    begin : g_bad_width
        $error("pfg_od_stage: WIDTH must match the drive struct width");
    end

    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (!od_en[i])
            begin
                drive.nmos_on[i] = doe[i] & ~dout[i];
                drive.pmos_on[i] = doe[i] & dout[i];
            end
            else if (!od_src[i])
            begin
                // Low side only: the ball can be pulled low or left floating.
                drive.nmos_on[i] = doe[i] & ~dout[i];
                drive.pmos_on[i] = 1'b0;
            end
            else
            begin
                drive.nmos_on[i] = 1'b0;
                drive.pmos_on[i] = doe[i] & dout[i];
            end
        end
    end

endmodule // pfg_od_stage

//--- dv/pfg_host_model.sv
// Purpose: Host-side model that issues byte register accesses to the pad configuration bank.
// Assumes: Strobes are one-cycle pulses launched on the falling clock edge.
// Notes: Idle address and data show the inverse of the last value, so stale values cannot pass.
module pfg_host_model
    import pfg_pkg::*;
(
    // Clock.
    input wire logic mclk,
    // Register access.
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask

    // Read data is registered at the read edge and taken half a cycle later, where it is settled.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge mclk);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        reg_addr = ~addr;
        data = reg_rdata;
    endtask

    // The reserved byte is read and written back unchanged before the selectors are updated.
    task automatic set_high_pull(input logic [7:0] sel);
        logic [7:0] keep;
        rd(PFG_ADDR_ROW_HIGH_PULL_HI, keep);
        wr(PFG_ADDR_ROW_HIGH_PULL_HI, keep);
        wr(PFG_ADDR_ROW_HIGH_PULL_LO, sel);
    endtask
endmodule // pfg_host_model

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the pad pull and open-drain configuration bank.
// Assumes: Inputs change on the falling clock edge; outputs are sampled there.
// Notes: Expected transistor controls are worked out here from the drive-source rules.
module tb_top
    import pfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TIMEOUT_CYCLES = 5000;
    logic mclk;
    logic resetn;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd;
    logic [7:0] col_dout, col_doe, row_dout, row_doe;
    logic [11:0] row_pull_up, row_pull_down;
    logic [7:0] col_od_en, col_od_src, row_od_en, row_od_src;
    logic [7:0] col_nmos_on, col_pmos_on, row_nmos_on, row_pmos_on;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    pfg_host_model i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    pfg_pad_config i_dut (.MCLK(mclk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .COL_DOUT(col_dout),
        .COL_DOE(col_doe), .ROW_DOUT(row_dout), .ROW_DOE(row_doe), .ROW_PULL_UP(row_pull_up),
        .ROW_PULL_DOWN(row_pull_down), .COL_OD_EN(col_od_en), .COL_OD_SRC(col_od_src),
        .ROW_OD_EN(row_od_en), .ROW_OD_SRC(row_od_src), .COL_NMOS_ON(col_nmos_on),
        .COL_PMOS_ON(col_pmos_on), .ROW_NMOS_ON(row_nmos_on), .ROW_PMOS_ON(row_pmos_on));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(addr, d);
        check(12'(d), 12'(exp));
    endtask

    // Push-pull drives both transistors; open-drain keeps only the one that the source bit picks.
    task automatic drive_checks(input logic [7:0] en, input logic [7:0] src);
        check(12'(col_nmos_on), 12'(col_doe & ~col_dout & ~(en & src)));
        check(12'(col_pmos_on), 12'(col_doe & col_dout & ~(en & ~src)));
        check(12'(row_nmos_on), 12'(row_doe & ~row_dout & ~(en & src)));
        check(12'(row_pmos_on), 12'(row_doe & row_dout & ~(en & ~src)));
        check(12'(col_od_en), 12'(en));
        check(12'(col_od_src), 12'(src));
        check(12'(row_od_src), 12'(src));
        rd_chk(PFG_ADDR_COL_OD_ENABLE, en);
        rd_chk(PFG_ADDR_COL_DRIVE_SOURCE, src);
        rd_chk(PFG_ADDR_ROW_OD_ENABLE, en);
        rd_chk(PFG_ADDR_ROW_DRIVE_SOURCE, src);
    endtask

    task automatic od_case(input logic [7:0] en, input logic [7:0] src);
        i_host.wr(PFG_ADDR_COL_OD_ENABLE, en);
        i_host.wr(PFG_ADDR_COL_DRIVE_SOURCE, src);
        i_host.wr(PFG_ADDR_ROW_OD_ENABLE, en);
        i_host.wr(PFG_ADDR_ROW_DRIVE_SOURCE, src);
        check(12'(row_od_en), 12'(en));
        drive_checks(en, src);
    endtask

    task automatic reset_checks();
        check(row_pull_down, 12'h7ff);
        check(row_pull_up, 12'h000);
        rd_chk(PFG_ADDR_ROW_LOW_PULL_LO, 8'h55);
        rd_chk(PFG_ADDR_ROW_LOW_PULL_HI, 8'h55);
        rd_chk(PFG_ADDR_ROW_HIGH_PULL_LO, 8'h15);
        rd_chk(PFG_ADDR_ROW_HIGH_PULL_HI, 8'h5a);
        drive_checks(8'h00, 8'h00);
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES)
        begin
            fails++;
            tally_and_finish();
        end
    end

    initial
    begin
        resetn = 1'b0;
        col_dout = 8'haa;
        col_doe = 8'hf3;
        row_dout = 8'h5a;
        row_doe = 8'hff;
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        reset_checks();
        // Selector codes 00, 01, 10 and 11 on rows 8 to 11, then 11, 10, 01, 00 on rows 0 to 3.
        i_host.set_high_pull(8'he4);
        check(row_pull_up, 12'hc00);
        check(row_pull_down, 12'h2ff);
        i_host.wr(PFG_ADDR_ROW_LOW_PULL_LO, 8'h1b);
        i_host.wr(PFG_ADDR_ROW_LOW_PULL_HI, 8'h00);
        check(row_pull_up, 12'hc03);
        check(row_pull_down, 12'h204);
        rd_chk(PFG_ADDR_ROW_HIGH_PULL_LO, 8'he4);
        rd_chk(PFG_ADDR_ROW_LOW_PULL_LO, 8'h1b);
        rd_chk(PFG_ADDR_ROW_LOW_PULL_HI, 8'h00);
        i_host.wr(PFG_ADDR_ROW_HIGH_PULL_HI, 8'hff);
        rd_chk(PFG_ADDR_ROW_HIGH_PULL_HI, 8'h5a);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h00, 8'h00);
        od_case(8'h00, 8'hff);
        od_case(8'h0f, 8'h05);
        od_case(8'hff, 8'h00);
        od_case(8'hff, 8'hff);
        // Flip the data so that every ball sees both levels in each open-drain stage.
        col_dout = 8'h55;
        row_dout = 8'ha5;
        od_case(8'hff, 8'h0f);
        od_case(8'hff, 8'hf0);
        resetn = 1'b0;
        @(negedge mclk);
        check(12'(col_od_en), 12'h000);
        resetn = 1'b1;
        @(negedge mclk);
        reset_checks();
        tally_and_finish();
    end
endmodule // tb_top
